// >>> rtl/mssxte_pkg.sv
package mssxte_pkg;

  // ==========================================================
  // Operations and states
  typedef enum logic [3:0] {
    OP_SUB_TO_WORKING = 4'h0,
    OP_MINUS_TO_MEMORY = 4'h1,
    OP_SUB_IMMEDIATE = 4'h2,
    OP_NIBBLE_EXCHANGE_TO_MEMORY = 4'h3,
    OP_NIBBLE_EXCHANGE_TO_WORKING = 4'h4,
    OP_SKIP_WHEN_ZERO = 4'h5,
    OP_COPY_AND_SKIP_WHEN_ZERO = 4'h6,
    OP_SKIP_WHEN_BIT_CLEAR = 4'h7,
    OP_TABLE_READ_CURRENT_PAGE = 4'h8,
    OP_TABLE_READ_LAST_PAGE = 4'h9,
    OP_EXCLUSIVE_OR_TO_WORKING = 4'hA,
    OP_EXCLUSIVE_OR_TO_MEMORY = 4'hB,
    OP_EXCLUSIVE_OR_IMMEDIATE = 4'hC,
    OP_NONE = 4'hF
  } mssxte_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b10,
    ST_DUMMY = 2'b11
  } mssxte_state_t;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADR_COMMAND = 8'h00;
  localparam logic [7:0] ADR_WORKING = 8'h04;
  localparam logic [7:0] ADR_FLAGS = 8'h08;
  localparam logic [7:0] ADR_TABLE_POINTER = 8'h0C;
  localparam logic [7:0] ADR_TABLE_HIGH = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;
  localparam logic [7:0] ADR_PAGE = 8'h18;

  // ==========================================================
  // Field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OPERAND_LSB = 8;
  localparam int CMD_BIT_LSB = 16;
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_HALF = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_OVERFLOW = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_SKIPPED = 1;
  localparam int STAT_CYCLES_LSB = 4;

  // ==========================================================
  // Widths and reset values
  localparam int ROM_W = 14;
  localparam int PAGE_W = 2;
  localparam logic [7:0] RST_WORKING = 8'h00;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [7:0] RST_TABLE_POINTER = 8'h00;
  localparam logic [5:0] RST_TABLE_HIGH = 6'h00;
  localparam logic [1:0] RST_PAGE = 2'h0;
  localparam logic [1:0] LAST_PAGE = 2'h3;
  localparam logic [1:0] CYCLES_PLAIN = 2'h1;
  localparam logic [1:0] CYCLES_SKIP = 2'h2;

  // ==========================================================
  // Timing
  localparam int INSTR_DIV_DEF = 4;

endpackage

// >>> rtl/mssxte_alu.sv
`timescale 1ns/10ps
module mssxte_alu
  import mssxte_pkg::*;
(
  input mssxte_op_t op_i,
  input logic [7:0] working_i,
  input logic [7:0] mem_i,
  input logic [7:0] imm_i,
  input logic [3:0] flags_i,
  output logic [7:0] result_o,
  output logic [3:0] flags_o,
  output logic wr_working_o,
  output logic wr_mem_o
);

  logic [7:0] sub_src;
  logic [8:0] diff;
  logic [4:0] half;

  // ==========================================================
  // Add complement plus one
  assign sub_src = (op_i == OP_SUB_IMMEDIATE) ? imm_i : mem_i;
  assign diff = {1'b0, working_i} + {1'b0, ~sub_src} + 9'h001;
  assign half = {1'b0, working_i[3:0]} + {1'b0, ~sub_src[3:0]} + 5'h01;

  // ==========================================================
  // Result and flags
  always_comb begin
    result_o = mem_i;
    flags_o = flags_i;
    wr_working_o = 1'b0;
    wr_mem_o = 1'b0;
    case (op_i)
      OP_SUB_TO_WORKING, OP_MINUS_TO_MEMORY, OP_SUB_IMMEDIATE: begin
        result_o = diff[7:0];
        flags_o[FLAG_CARRY] = diff[8];
        flags_o[FLAG_HALF] = half[4];
        flags_o[FLAG_ZERO] = (diff[7:0] == 8'h00);
        flags_o[FLAG_OVERFLOW] = (working_i[7] ^ sub_src[7]) & (working_i[7] ^ diff[7]);
        wr_mem_o = (op_i == OP_MINUS_TO_MEMORY);
        wr_working_o = (op_i != OP_MINUS_TO_MEMORY);
      end
      OP_NIBBLE_EXCHANGE_TO_MEMORY: begin
        result_o = {mem_i[3:0], mem_i[7:4]};
        wr_mem_o = 1'b1;
      end
      OP_NIBBLE_EXCHANGE_TO_WORKING: begin
        result_o = {mem_i[3:0], mem_i[7:4]};
        wr_working_o = 1'b1;
      end
      OP_COPY_AND_SKIP_WHEN_ZERO: begin
        result_o = mem_i;
        wr_working_o = 1'b1;
      end
      OP_EXCLUSIVE_OR_TO_WORKING, OP_EXCLUSIVE_OR_TO_MEMORY: begin
        result_o = working_i ^ mem_i;
        flags_o[FLAG_ZERO] = ((working_i ^ mem_i) == 8'h00);
        wr_mem_o = (op_i == OP_EXCLUSIVE_OR_TO_MEMORY);
        wr_working_o = (op_i == OP_EXCLUSIVE_OR_TO_WORKING);
      end
      OP_EXCLUSIVE_OR_IMMEDIATE: begin
        result_o = working_i ^ imm_i;
        flags_o[FLAG_ZERO] = ((working_i ^ imm_i) == 8'h00);
        wr_working_o = 1'b1;
      end
      default: begin
        result_o = mem_i;
      end
    endcase
  end

endmodule

// >>> rtl/mssxte_skip.sv
`timescale 1ns/10ps
module mssxte_skip
  import mssxte_pkg::*;
(
  input mssxte_op_t op_i,
  input logic [7:0] mem_i,
  input logic [2:0] bit_i,
  output logic skip_o
);

  // ==========================================================
  // Skip decision
  always_comb begin
    case (op_i)
      OP_SKIP_WHEN_ZERO: skip_o = (mem_i == 8'h00);
      OP_COPY_AND_SKIP_WHEN_ZERO: skip_o = (mem_i == 8'h00);
      OP_SKIP_WHEN_BIT_CLEAR: skip_o = ~mem_i[bit_i];
      default: skip_o = 1'b0;
    endcase
  end

endmodule

// >>> rtl/mssxte_core.sv
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
module mssxte_core
  import mssxte_pkg::*;
#(
  parameter int INSTR_DIV = INSTR_DIV_DEF
) (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [7:0] dmem_addr_o,
  input logic [7:0] dmem_rdata_i,
  output logic dmem_we_o,
  output logic [7:0] dmem_wdata_o,
  output logic [9:0] pmem_addr_o,
  output logic pmem_rd_o,
  input logic [13:0] pmem_rdata_i,
  output logic prefetch_discard_o,
  output logic dummy_cycle_o,
  output logic busy_o
);

  mssxte_state_t state_q;
  mssxte_op_t op_q;
  logic [7:0] operand_q;
  logic [2:0] bit_q;
  logic [7:0] working_q;
  logic [3:0] flags_q;
  logic [7:0] table_pointer_q;
  logic [5:0] table_high_q;
  logic [1:0] page_q;
  logic skipped_q;
  logic [1:0] cycles_q;
  logic [7:0] div_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [7:0] dmem_addr_q;
  logic dmem_we_q;
  logic [7:0] dmem_wdata_q;
  logic [9:0] pmem_addr_q;
  logic pmem_rd_q;
  logic discard_q;
  logic bus_req;
  logic bus_wr;
  logic start;
  logic tick;
  logic exec_fire;
  logic is_table;
  logic [7:0] alu_result;
  logic [3:0] alu_flags;
  logic alu_wr_working;
  logic alu_wr_mem;
  logic skip;

  // ==========================================================
  // Wishbone slave
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & ack_q & wb_sel_i[0];
  assign start = bus_wr & (wb_adr_i == ADR_COMMAND) & (state_q == ST_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (wb_adr_i)
      ADR_COMMAND: begin
        rdata_d[CMD_OP_LSB +: 4] = op_q;
        rdata_d[CMD_OPERAND_LSB +: 8] = operand_q;
        rdata_d[CMD_BIT_LSB +: 3] = bit_q;
      end
      ADR_WORKING: rdata_d[7:0] = working_q;
      ADR_FLAGS: rdata_d[3:0] = flags_q;
      ADR_TABLE_POINTER: rdata_d[7:0] = table_pointer_q;
      ADR_TABLE_HIGH: rdata_d[5:0] = table_high_q;
      ADR_STATUS: begin
        rdata_d[STAT_BUSY] = (state_q != ST_IDLE);
        rdata_d[STAT_SKIPPED] = skipped_q;
        rdata_d[STAT_CYCLES_LSB +: 2] = cycles_q;
      end
      ADR_PAGE: rdata_d[1:0] = page_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_req & ~ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ==========================================================
  // Command capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_q <= OP_NONE;
      operand_q <= 8'h00;
      bit_q <= 3'h0;
    end else if (start) begin
      op_q <= mssxte_op_t'(wb_dat_i[CMD_OP_LSB +: 4]);
      operand_q <= wb_dat_i[CMD_OPERAND_LSB +: 8];
      bit_q <= wb_dat_i[CMD_BIT_LSB +: 3];
    end
  end

  assign is_table = (op_q == OP_TABLE_READ_CURRENT_PAGE) | (op_q == OP_TABLE_READ_LAST_PAGE);

  // ==========================================================
  // Instruction cycle divider
  assign tick = ((state_q == ST_EXEC) | (state_q == ST_DUMMY)) &
                (div_q == 8'(INSTR_DIV - 1));
  assign exec_fire = (state_q == ST_EXEC) & tick;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 8'h00;
    end else if ((state_q == ST_FETCH) | tick) begin
      div_q <= 8'h00;
    end else if (state_q != ST_IDLE) begin
      div_q <= div_q + 8'h01;
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: state_q <= ST_EXEC;
        ST_EXEC: begin
          if (tick) begin
            state_q <= skip ? ST_DUMMY : ST_IDLE;
          end
        end
        ST_DUMMY: begin
          if (tick) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Datapath leaves
  mssxte_alu u_alu (
    .op_i(op_q),
    .working_i(working_q),
    .mem_i(dmem_rdata_i),
    .imm_i(operand_q),
    .flags_i(flags_q),
    .result_o(alu_result),
    .flags_o(alu_flags),
    .wr_working_o(alu_wr_working),
    .wr_mem_o(alu_wr_mem)
  );

  mssxte_skip u_skip (
    .op_i(op_q),
    .mem_i(dmem_rdata_i),
    .bit_i(bit_q),
    .skip_o(skip)
  );

  // ==========================================================
  // Working register and flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      working_q <= RST_WORKING;
    end else if (exec_fire & alu_wr_working) begin
      working_q <= alu_result;
    end else if (bus_wr & (wb_adr_i == ADR_WORKING)) begin
      working_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= RST_FLAGS;
    end else if (exec_fire) begin
      flags_q <= alu_flags;
    end else if (bus_wr & (wb_adr_i == ADR_FLAGS)) begin
      flags_q <= wb_dat_i[3:0];
    end
  end

  // ==========================================================
  // Table pointer, page, high byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      table_pointer_q <= RST_TABLE_POINTER;
    end else if (bus_wr & (wb_adr_i == ADR_TABLE_POINTER)) begin
      table_pointer_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_q <= RST_PAGE;
    end else if (bus_wr & (wb_adr_i == ADR_PAGE)) begin
      page_q <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      table_high_q <= RST_TABLE_HIGH;
    end else if (exec_fire & is_table) begin
      table_high_q <= pmem_rdata_i[ROM_W-1:8];
    end
  end

  // ==========================================================
  // Program memory port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pmem_addr_q <= 10'h000;
    end else if (start) begin
      if (wb_dat_i[CMD_OP_LSB +: 4] == OP_TABLE_READ_LAST_PAGE) begin
        pmem_addr_q <= {LAST_PAGE, table_pointer_q};
      end else begin
        pmem_addr_q <= {page_q, table_pointer_q};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pmem_rd_q <= 1'b0;
    end else if ((state_q == ST_FETCH) & is_table) begin
      pmem_rd_q <= 1'b1;
    end else if (exec_fire) begin
      pmem_rd_q <= 1'b0;
    end
  end

  // ==========================================================
  // Data memory port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dmem_addr_q <= 8'h00;
    end else if (start) begin
      dmem_addr_q <= wb_dat_i[CMD_OPERAND_LSB +: 8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dmem_we_q <= 1'b0;
      dmem_wdata_q <= 8'h00;
    end else begin
      dmem_we_q <= exec_fire & (alu_wr_mem | is_table);
      if (exec_fire) begin
        dmem_wdata_q <= is_table ? pmem_rdata_i[7:0] : alu_result;
      end
    end
  end

  // ==========================================================
  // Skip reporting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skipped_q <= 1'b0;
      cycles_q <= 2'h0;
      discard_q <= 1'b0;
    end else begin
      discard_q <= exec_fire & skip;
      if (start) begin
        skipped_q <= 1'b0;
      end else if (exec_fire) begin
        skipped_q <= skip;
        cycles_q <= skip ? CYCLES_SKIP : CYCLES_PLAIN;
      end
    end
  end

  assign dmem_addr_o = dmem_addr_q;
  assign dmem_we_o = dmem_we_q;
  assign dmem_wdata_o = dmem_wdata_q;
  assign pmem_addr_o = pmem_addr_q;
  assign pmem_rd_o = pmem_rd_q;
  assign prefetch_discard_o = discard_q;
  assign dummy_cycle_o = (state_q == ST_DUMMY);
  assign busy_o = (state_q != ST_IDLE);

endmodule

// >>> bench/mssxte_props.sv
`timescale 1ns/10ps
// ==========
// Port checker
module mssxte_props
  import mssxte_pkg::*;
#(
  parameter int INSTR_DIV = INSTR_DIV_DEF
) (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic wb_ack_o,
  input logic dmem_we_o,
  input logic pmem_rd_o,
  input logic prefetch_discard_o,
  input logic dummy_cycle_o,
  input logic busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  localparam logic [7:0] PLAIN_N = 8'(INSTR_DIV + 1);
  localparam logic [7:0] DUMMY_N = 8'(INSTR_DIV);
  logic [7:0] dcnt_q;
  logic [7:0] bcnt_q;
  // ==========
  // Cycle counters
  always_ff @(posedge clk_i) begin
    dcnt_q <= (rst_i || !dummy_cycle_o) ? 8'h00 : dcnt_q + 8'h01;
  end
  always_ff @(posedge clk_i) begin
    bcnt_q <= (rst_i || !busy_o) ? 8'h00 : bcnt_q + 8'h01;
  end
  // ==========
  // Assertions
  ack_after_req_a :
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
  start_on_command_a :
    assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_COMMAND
      && !busy_o |=> busy_o) else $error("command did not start");
  discard_has_dummy_a :
    assert property (prefetch_discard_o |-> dummy_cycle_o && busy_o)
    else $error("discard without dummy cycle");
  discard_one_pulse_a :
    assert property (prefetch_discard_o |=> !prefetch_discard_o)
    else $error("discard longer than one cycle");
  discard_no_write_a :
    assert property (prefetch_discard_o |-> !dmem_we_o)
    else $error("skip wrote memory");
  dummy_length_a :
    assert property ($fell(dummy_cycle_o) && !$past(rst_i) |-> dcnt_q == DUMMY_N)
    else $error("dummy cycle length wrong");
  busy_length_a :
    assert property ($fell(busy_o) && !$past(rst_i) |->
      bcnt_q == PLAIN_N + ($past(dummy_cycle_o) ? DUMMY_N : 8'h00))
    else $error("instruction length wrong");
  mem_write_end_a :
    assert property (dmem_we_o |-> !busy_o && $past(busy_o) ##1 !dmem_we_o)
    else $error("memory write out of place");
  table_read_busy_a :
    assert property (pmem_rd_o |-> busy_o && !dummy_cycle_o)
    else $error("program read outside execution");
  table_read_end_a :
    assert property ($fell(pmem_rd_o) && !$past(rst_i) |-> $fell(busy_o))
    else $error("program read end misplaced");
  cover property (prefetch_discard_o);
  cover property (dmem_we_o);
  cover property (pmem_rd_o);
endmodule

bind mssxte_core mssxte_props #(.INSTR_DIV(INSTR_DIV)) u_props (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_ack_o, .dmem_we_o, .pmem_rd_o,
  .prefetch_discard_o, .dummy_cycle_o, .busy_o);

// >>> bench/mcu_subtract_swap_skip_xor_table_exec_bench.sv
`timescale 1ns/10ps
// ==========
// Execution core bench
module mcu_subtract_swap_skip_xor_table_exec_bench
  import mssxte_pkg::*;
();
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] dmem_addr_o;
  logic [7:0] dmem_rdata_i = 8'h00;
  logic dmem_we_o;
  logic [7:0] dmem_wdata_o;
  logic [9:0] pmem_addr_o;
  logic pmem_rd_o;
  logic [13:0] pmem_rdata_i = 14'h0;
  logic prefetch_discard_o;
  logic dummy_cycle_o;
  logic busy_o;
  logic [7:0] mem [256];
  logic [31:0] q;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;

  mssxte_core #(.INSTR_DIV(3)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dmem_addr_o, .dmem_rdata_i,
    .dmem_we_o, .dmem_wdata_o, .pmem_addr_o, .pmem_rd_o, .pmem_rdata_i,
    .prefetch_discard_o, .dummy_cycle_o, .busy_o);

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========
  // Memories and timeout
  always @(posedge clk_i) begin
    dmem_rdata_i <= mem[dmem_addr_o];
    pmem_rdata_i <= {pmem_addr_o, 4'h9};
    if (dmem_we_o === 1'b1) mem[dmem_addr_o] <= dmem_wdata_o;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // ==========
  // Tasks
  task automatic close_out();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0, 4'hF);
  endtask

  task automatic idle();
    repeat (2) @(posedge clk_i);
    while (busy_o === 1'b1) @(posedge clk_i);
    @(posedge clk_i);
  endtask

  task automatic run(input mssxte_op_t op, input logic [7:0] opnd, input logic [2:0] bn,
    input logic [7:0] w0, input logic [3:0] f0, input logic [7:0] m0, input logic [7:0] ew,
    input logic [3:0] ef, input logic [7:0] em, input logic [7:0] es);
    mem[opnd] = m0;
    wr(ADR_WORKING, {24'h0, w0});
    wr(ADR_FLAGS, {28'h0, f0});
    wr(ADR_COMMAND, {13'h0, bn, opnd, 4'h0, op});
    idle();
    rd(ADR_WORKING);
    chk(q, {24'h0, ew});
    rd(ADR_FLAGS);
    chk(q, {28'h0, ef});
    rd(ADR_STATUS);
    chk(q, {24'h0, es});
    chk({24'h0, mem[opnd]}, {24'h0, em});
  endtask

  // ==========
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADR_COMMAND);
    chk(q & 32'hF, 32'hF);
    wr(8'h1C, 32'hFF);
    rd(8'h1C);
    chk(q, 32'h0);
    xfer(1'b1, ADR_PAGE, 32'h3, 4'hE);
    rd(ADR_PAGE);
    chk(q, 32'h0);
    run(OP_SUB_TO_WORKING, 8'h20, 3'h0, 8'h42, 4'h8, 8'h42, 8'h00, 4'h7, 8'h42, 8'h10);
    run(OP_MINUS_TO_MEMORY, 8'h21, 3'h0, 8'h30, 4'h5, 8'h50, 8'h30, 4'h2, 8'hE0,
      8'h10);
    run(OP_SUB_IMMEDIATE, 8'h01, 3'h0, 8'h80, 4'h0, 8'h33, 8'h7F, 4'h9, 8'h33, 8'h10);
    run(OP_NIBBLE_EXCHANGE_TO_MEMORY, 8'h22, 3'h0, 8'h11, 4'hF, 8'h3C, 8'h11, 4'hF, 8'hC3,
      8'h10);
    run(OP_NIBBLE_EXCHANGE_TO_WORKING, 8'h23, 3'h0, 8'h11, 4'h0, 8'hA5, 8'h5A, 4'h0, 8'hA5,
      8'h10);
    run(OP_SKIP_WHEN_ZERO, 8'h24, 3'h0, 8'h11, 4'hA, 8'h00, 8'h11, 4'hA, 8'h00, 8'h22);
    run(OP_SKIP_WHEN_ZERO, 8'h24, 3'h0, 8'h11, 4'h5, 8'h01, 8'h11, 4'h5, 8'h01, 8'h10);
    run(OP_COPY_AND_SKIP_WHEN_ZERO, 8'h25, 3'h0, 8'h11, 4'hF, 8'h00, 8'h00, 4'hF, 8'h00,
      8'h22);
    run(OP_COPY_AND_SKIP_WHEN_ZERO, 8'h25, 3'h0, 8'h11, 4'h0, 8'h80, 8'h80, 4'h0, 8'h80,
      8'h10);
    for (int i = 0; i < 8; i++) begin
      run(OP_SKIP_WHEN_BIT_CLEAR, 8'h26, 3'(i), 8'h11, 4'h3, ~(8'h01 << i), 8'h11, 4'h3,
        ~(8'h01 << i), 8'h22);
      run(OP_SKIP_WHEN_BIT_CLEAR, 8'h26, 3'(i), 8'h11, 4'h3, 8'h01 << i, 8'h11, 4'h3,
        8'h01 << i, 8'h10);
    end
    run(OP_EXCLUSIVE_OR_TO_WORKING, 8'h27, 3'h0, 8'hF0, 4'hF, 8'h3C, 8'hCC, 4'hB, 8'h3C,
      8'h10);
    run(OP_EXCLUSIVE_OR_TO_MEMORY, 8'h28, 3'h0, 8'h5A, 4'h0, 8'h5A, 8'h5A, 4'h4, 8'h00,
      8'h10);
    run(OP_EXCLUSIVE_OR_IMMEDIATE, 8'h96, 3'h0, 8'h69, 4'hF, 8'h33, 8'hFF, 4'hB, 8'h33,
      8'h10);
    wr(ADR_PAGE, 32'h1);
    wr(ADR_TABLE_POINTER, 32'h5A);
    run(OP_TABLE_READ_CURRENT_PAGE, 8'h29, 3'h0, 8'h11, 4'h6, 8'h00, 8'h11, 4'h6, 8'hA9,
      8'h10);
    rd(ADR_TABLE_HIGH);
    chk(q, 32'h15);
    wr(ADR_TABLE_POINTER, 32'hC3);
    run(OP_TABLE_READ_LAST_PAGE, 8'h2A, 3'h0, 8'h11, 4'h9, 8'h00, 8'h11, 4'h9, 8'h39,
      8'h10);
    rd(ADR_TABLE_HIGH);
    chk(q, 32'h3C);
    wr(ADR_COMMAND, {16'h0, 8'h0F, 4'h0, OP_EXCLUSIVE_OR_IMMEDIATE});
    wr(ADR_COMMAND, {16'h0, 8'h01, 4'h0, OP_SUB_IMMEDIATE});
    idle();
    rd(ADR_WORKING);
    chk(q, 32'h1E);
    close_out();
  end
endmodule
